// ---- shared/rpbo_map.svh ----
// Constants for the reset pin role and bitstream output block.
// Assumes inclusion by bare name from design and bench files.
`ifndef RPBO_MAP_SVH
`define RPBO_MAP_SVH
// ========================================
// Register indices and addresses
`define RPBO_ADDR_W        4
`define RPBO_CTRL_ADDR     4'h0
`define RPBO_STAT_ADDR     4'h4
`define RPBO_OSR_ADDR      4'h8
// ========================================
// Control field positions
`define RPBO_CTRL_EXTREF   0
`define RPBO_CTRL_BSOE     1
`define RPBO_CTRL_RESET    2'h0
// ========================================
// Status field positions
`define RPBO_STAT_MODE     0
`define RPBO_STAT_INRST    1
`define RPBO_STAT_CLKRUN   2
`define RPBO_STAT_SETTLE   3
`define RPBO_STAT_INTREF   4
// ========================================
// Timing: analog clock divider, idle-clock detection window and cold-start settle window
`define RPBO_ACLK_DIV      8'h04
`define RPBO_IDLE_CYC      8'h20
`define RPBO_SETTLE_CYC    8'h40
`endif

// ---- shared/rpbo_pkg.sv ----
// Types for the reset pin role and bitstream output block.
// Assumes the map header supplies the numeric constants.
package rpbo_pkg;
	// ========================================
	// Interface mode state, Gray coded along the usual path.
	typedef enum logic [1:0] {
		RPBO_ST_RESET = 2'h0,
		RPBO_ST_SPI   = 2'h1,
		RPBO_ST_TWO   = 2'h3
	} rpbo_state_t;
endpackage

// ---- src/rpbo_buf2.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module rpbo_buf2 (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic flush,
	input  wire logic in_valid,
	output logic      in_ready,
	input  wire logic in_data,
	output logic      out_valid,
	input  wire logic out_ready,
	output logic      out_data
);
	logic [1:0] data_reg;
	logic [1:0] cnt_reg;
	wire        push = in_valid && in_ready;
	wire        pop  = out_valid && out_ready;
	// ========================================
	// Handshakes come straight from the fill count.
	assign in_ready  = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = data_reg[0];
	// Entry zero is the head; a pop shifts entry one down.
	always_ff @(posedge clock) begin
		if (rst || (clk_en && flush)) begin
			data_reg <= 2'h0;
			cnt_reg  <= 2'h0;
		end else if (clk_en) begin
			if (pop) begin
				data_reg[0] <= (cnt_reg == 2'h2) ? data_reg[1] : in_data;
			end else if (push && cnt_reg == 2'h0) begin
				data_reg[0] <= in_data;
			end
			if (push && ((cnt_reg == 2'h1 && !pop) || cnt_reg == 2'h2)) begin
				data_reg[1] <= in_data;
			end
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // rpbo_buf2

// ---- src/rpbo_sync3.sv ----
// Three-stage synchroniser for one pin with agreement filter.
// Assumes a single clock; the pin is asynchronous to it.
`timescale 1ns/1ns
module rpbo_sync3 (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic pin_in,
	input  wire logic reset_val,
	output logic      level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// ========================================
	// Shift chain; a change counts once stage two and three agree.
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_reg <= reset_val;
			s2_reg <= reset_val;
			s3_reg <= reset_val;
			level_out <= reset_val;
		end else if (clk_en) begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_out <= s3_reg;
			end
		end
	end
endmodule // rpbo_sync3

// ---- src/rpbo_top.sv ----
// Reset pin roles, reference select and bitstream output gating.
// Assumes pins arrive asynchronously and the master clock is sampled.
`timescale 1ns/1ns
`include "rpbo_map.svh"
// Functional notes
// - SPI mode: low reset pin holds chip
// - Reset clears registers, blocks communication
// - In reset only input structure clocked
// - Idle master clock: no clock at all
// - Running clock in reset keeps biases on
// - Absent clock: first conversions may be inaccurate
// - Two-wire: reset pin latched as oversample select
// - External reference bit set: internal off
// - Bit clear: internal reference onto pin
// - Bitstream pin floats while enable clear
// - Enabled: bitstream driven once per analog clock
// - Bitstream enabled disables conversion-ready output
// - Two-wire mode: bitstream pin always floats
// - Mode pin high two-wire, low SPI
// - Mode pin latched at resets, held
module rpbo_top
	import rpbo_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    clk_en,
	input  wire logic                    reset_n_pin,
	input  wire logic                    mode_pin,
	input  wire logic                    mclk_pin,
	input  wire logic                    watchdog_reset,
	input  wire logic [`RPBO_ADDR_W-1:0] addr,
	input  wire logic [31:0]             wdata,
	input  wire logic                    wr_stb,
	input  wire logic                    rd_stb,
	output logic [31:0]                  rdata,
	input  wire logic                    mod_bit,
	output logic                         mod_bit_ready,
	input  wire logic                    conv_ready,
	output logic                         bitstream_out_pin,
	output logic                         bitstream_out_pin_oe,
	output logic                         conversion_ready_pin,
	output logic                         conversion_ready_pin_oe,
	output logic                         oversample_select_low,
	output logic                         internal_ref_enable,
	output logic                         ref_switch_on,
	output logic                         analog_bias_enable,
	output logic                         input_clock_enable,
	output logic                         core_clock_enable,
	output logic                         core_reset,
	output logic                         comm_enable,
	output logic                         analog_master_clock
);
	// ========================================
	// Pin synchronisers.
	logic reset_n_s;
	logic mode_s;
	logic mclk_s;
	rpbo_sync3 u_sync_rst (
		.clock     (clock),
		.rst       (rst),
		.clk_en    (clk_en),
		.pin_in    (reset_n_pin),
		.reset_val (1'b1),
		.level_out (reset_n_s)
	);
	rpbo_sync3 u_sync_mode (
		.clock     (clock),
		.rst       (rst),
		.clk_en    (clk_en),
		.pin_in    (mode_pin),
		.reset_val (1'b0),
		.level_out (mode_s)
	);
	rpbo_sync3 u_sync_mclk (
		.clock     (clock),
		.rst       (rst),
		.clk_en    (clk_en),
		.pin_in    (mclk_pin),
		.reset_val (1'b0),
		.level_out (mclk_s)
	);

	// ========================================
	// State registers.
	rpbo_state_t state_reg;
	rpbo_state_t state_next;
	logic [1:0]  ctrl_reg;
	logic        osr_low_reg;
	logic        mclk_d_reg;
	logic [7:0]  idle_cnt_reg;
	logic        clk_run_reg;
	logic        cold_reg;
	logic [7:0]  settle_cnt_reg;
	logic [7:0]  div_cnt_reg;
	logic        aclk_reg;
	logic        bs_reg;
	logic        bs_valid_reg;
	logic        rd_pend_reg;
	logic [31:0] rd_data_reg;

	// ========================================
	// Mode decode: a low pin in SPI mode is a hard chip reset.
	wire two_wire   = (state_reg == RPBO_ST_TWO);
	wire spi_mode   = (state_reg == RPBO_ST_SPI);
	// While re-latching, the pin only resets if SPI mode will follow.
	wire next_two   = (state_reg == RPBO_ST_RESET) ? mode_s : two_wire;
	wire hard_rst   = !next_two && !reset_n_s;
	wire relatch    = (state_reg == RPBO_ST_RESET) || watchdog_reset;
	wire mclk_edge  = mclk_s ^ mclk_d_reg;
	wire ext_ref    = ctrl_reg[`RPBO_CTRL_EXTREF];
	wire bs_enable  = ctrl_reg[`RPBO_CTRL_BSOE] && !two_wire;

	// ========================================
	// Interface mode selection from the latched mode pin.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RPBO_ST_RESET: begin
				state_next = mode_s ? RPBO_ST_TWO : RPBO_ST_SPI;
			end
			RPBO_ST_SPI: begin
				if (watchdog_reset || hard_rst) begin
					state_next = RPBO_ST_RESET;
				end
			end
			RPBO_ST_TWO: begin
				if (watchdog_reset) begin
					state_next = RPBO_ST_RESET;
				end
			end
			default: begin
				state_next = RPBO_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= RPBO_ST_RESET;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ========================================
	// Oversample select low: latched on two-wire mode entry and on watchdog resets in two-wire mode.
	always_ff @(posedge clock) begin
		if (rst) begin
			osr_low_reg <= 1'b0;
		end else if (clk_en && relatch && (state_next == RPBO_ST_TWO
				|| two_wire)) begin
			osr_low_reg <= reset_n_s;
		end
	end
	assign oversample_select_low = osr_low_reg;

	// ========================================
	// Master clock activity detector on the sampled pin.
	always_ff @(posedge clock) begin
		if (rst) begin
			mclk_d_reg   <= 1'b0;
			idle_cnt_reg <= 8'h00;
			clk_run_reg  <= 1'b0;
		end else if (clk_en) begin
			mclk_d_reg <= mclk_s;
			if (mclk_edge) begin
				idle_cnt_reg <= 8'h00;
				clk_run_reg  <= 1'b1;
			end else if (idle_cnt_reg == `RPBO_IDLE_CYC) begin
				clk_run_reg  <= 1'b0;
			end else begin
				idle_cnt_reg <= idle_cnt_reg + 8'h01;
			end
		end
	end

	// ========================================
	// Cold start tracking: reset without clock leaves a settle window.
	always_ff @(posedge clock) begin
		if (rst) begin
			cold_reg       <= 1'b1;
			settle_cnt_reg <= 8'h00;
		end else if (clk_en) begin
			if (hard_rst) begin
				if (!clk_run_reg) begin
					cold_reg <= 1'b1;
				end
				settle_cnt_reg <= 8'h00;
			end else if (cold_reg && clk_run_reg) begin
				if (settle_cnt_reg == `RPBO_SETTLE_CYC) begin
					cold_reg <= 1'b0;
				end else begin
					settle_cnt_reg <= settle_cnt_reg + 8'h01;
				end
			end
		end
	end

	// ========================================
	// Clock and bias distribution during and after reset.
	assign core_reset          = hard_rst;
	assign core_clock_enable   = !hard_rst && clk_run_reg;
	assign input_clock_enable  = clk_run_reg;
	assign analog_bias_enable  = !hard_rst || clk_run_reg;
	assign comm_enable         = spi_mode && !hard_rst;

	// ========================================
	// Reference selection.
	assign internal_ref_enable = !ext_ref;
	assign ref_switch_on       = !ext_ref;

	// ========================================
	// Analog master clock divider; stopped in hard reset.
	always_ff @(posedge clock) begin
		if (rst || (clk_en && hard_rst)) begin
			div_cnt_reg <= 8'h00;
			aclk_reg    <= 1'b0;
		end else if (clk_en && clk_run_reg) begin
			if (div_cnt_reg == `RPBO_ACLK_DIV - 8'h01) begin
				div_cnt_reg <= 8'h00;
				aclk_reg    <= !aclk_reg;
			end else begin
				div_cnt_reg <= div_cnt_reg + 8'h01;
			end
		end
	end
	assign analog_master_clock = aclk_reg;
	wire aclk_rise = clk_en && clk_run_reg && !aclk_reg
		&& (div_cnt_reg == `RPBO_ACLK_DIV - 8'h01);

	// ========================================
	// Bitstream buffer; drained one bit per analog clock cycle.
	logic buf_valid;
	logic buf_data;
	rpbo_buf2 u_buf (
		.clock     (clock),
		.rst       (rst),
		.clk_en    (clk_en),
		.flush     (!bs_enable || hard_rst),
		.in_valid  (1'b1),
		.in_ready  (mod_bit_ready),
		.in_data   (mod_bit),
		.out_valid (buf_valid),
		.out_ready (aclk_rise),
		.out_data  (buf_data)
	);

	always_ff @(posedge clock) begin
		if (rst || (clk_en && hard_rst)) begin
			bs_reg       <= 1'b0;
			bs_valid_reg <= 1'b0;
		end else if (clk_en) begin
			if (!bs_enable) begin
				bs_valid_reg <= 1'b0;
			end else if (aclk_rise && buf_valid) begin
				bs_reg       <= buf_data;
				bs_valid_reg <= 1'b1;
			end
		end
	end
	assign bitstream_out_pin    = bs_reg;
	assign bitstream_out_pin_oe = bs_enable && bs_valid_reg;

	// ========================================
	// Conversion-ready pin, silenced while the bitstream is out.
	assign conversion_ready_pin    = !conv_ready;
	assign conversion_ready_pin_oe = spi_mode && !hard_rst
		&& !bs_enable;

	// ========================================
	// Register write; control returns to default in hard reset.
	wire wr_ctrl = wr_stb && (addr == `RPBO_CTRL_ADDR) && comm_enable;
	always_ff @(posedge clock) begin
		if (rst || (clk_en && hard_rst)) begin
			ctrl_reg <= `RPBO_CTRL_RESET;
		end else if (clk_en && wr_ctrl) begin
			ctrl_reg <= wdata[1:0];
		end
	end

	// ========================================
	// Register read; data stand for one cycle after the strobe.
	wire [31:0] stat_word = {27'h0, !ext_ref, cold_reg,
		clk_run_reg, hard_rst, two_wire};
	wire [31:0] rd_mux =
		(addr == `RPBO_CTRL_ADDR) ? {30'h0, ctrl_reg} :
		(addr == `RPBO_STAT_ADDR) ? stat_word :
		(addr == `RPBO_OSR_ADDR)  ? {31'h0, osr_low_reg} :
		32'h00000000;
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_pend_reg <= 1'b0;
			rd_data_reg <= 32'h00000000;
		end else if (clk_en) begin
			rd_pend_reg <= rd_stb;
			rd_data_reg <= (rd_stb && comm_enable) ? rd_mux
				: 32'h00000000;
		end
	end
	assign rdata = rd_pend_reg ? rd_data_reg : 32'h00000000;
endmodule // rpbo_top

// ---- tb/rpbo_host_model.sv ----
// Host that captures the modulator bitstream from the output pin.
// Assumes the analog clock and pin are sampled on the block's clock.
`timescale 1ns/1ns
module rpbo_host_model (
	input wire logic  clock,
	input wire logic  rst,
	input wire logic  analog_master_clock,
	input wire logic  bitstream_out_pin,
	input wire logic  bitstream_out_pin_oe,
	output logic [7:0] bit_cnt,
	output logic       last_bit
);
	logic aclk_prev;
	// ========================================
	// One bit per analog clock rise, only while the pin is driven.
	always_ff @(posedge clock) begin
		aclk_prev <= analog_master_clock;
		if (rst) begin
			bit_cnt <= 8'h00;
			last_bit <= 1'h0;
		end else if (analog_master_clock && !aclk_prev &&
			bitstream_out_pin_oe) begin
			bit_cnt <= bit_cnt + 8'h01;
			last_bit <= bitstream_out_pin;
		end
	end
endmodule // rpbo_host_model

// ---- tb/rpbo_top_properties.sv ----
// Port checker for the reset pin role and bitstream block.
// Assumes a bind onto rpbo_top and one clock domain.
`timescale 1ns/1ns
module rpbo_top_properties (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        rd_stb,
	input wire logic [31:0] rdata,
	input wire logic        comm_enable,
	input wire logic        bitstream_out_pin,
	input wire logic        bitstream_out_pin_oe,
	input wire logic        conversion_ready_pin_oe,
	input wire logic        internal_ref_enable,
	input wire logic        ref_switch_on,
	input wire logic        analog_bias_enable,
	input wire logic        input_clock_enable,
	input wire logic        core_clock_enable,
	input wire logic        core_reset,
	input wire logic        analog_master_clock
);
	// ========================================
	// Relations between outputs over time.
	default clocking dcb @(posedge clock); endclocking
	default disable iff (rst);
	a_ref_pair_match: assert property (
		internal_ref_enable == ref_switch_on)
		else $error("reference enable and switch differ");
	a_ready_pin_off: assert property (
		bitstream_out_pin_oe |-> !conversion_ready_pin_oe)
		else $error("ready pin driven beside bitstream");
	a_bit_hold_period: assert property (
		$changed(bitstream_out_pin) && bitstream_out_pin_oe &&
		$past(bitstream_out_pin_oe) |=>
		($stable(bitstream_out_pin) || !bitstream_out_pin_oe)[*7])
		else $error("bitstream changed inside one period");
	a_aclk_period: assert property (
		$rose(analog_master_clock) |=> (!$rose(analog_master_clock))[*7])
		else $error("analog clock period too short");
	a_regs_cleared: assert property (
		disable iff (1'h0) $fell(rst) |-> rdata == 32'h0)
		else $error("read data not cleared by reset");
	a_read_refused: assert property (
		rd_stb && !comm_enable |=> rdata == 32'h0)
		else $error("read answered while access is refused");
	a_core_clk_stop: assert property (
		core_reset |-> !core_clock_enable)
		else $error("core clock runs during chip reset");
	a_bias_kept_on: assert property (
		core_reset && input_clock_enable |-> analog_bias_enable)
		else $error("biases off while clock runs in reset");
endmodule // rpbo_top_properties

// ---- tb/test_rpbo_top.sv ----
// Bench for reset pin roles, reference select and bitstream gating.
// Assumes the block, its checker and the host model compile first.
`timescale 1ns/1ns
`include "rpbo_map.svh"
`define CHK(a, e) chk(32'(a), 32'(e))
module test_rpbo_top;
	// ========================================
	// Pins and bench state.
	logic        clock = 1'h0, rst = 1'h1, reset_n_pin = 1'h1;
	logic        mode_pin = 1'h0, mclk_pin = 1'h0, mclk_run = 1'h1;
	logic        watchdog_reset = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0;
	logic        conv_ready = 1'h0;
	logic        mod_bit = 1'h0, last_bit, mod_bit_ready;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [7:0]  bit_cnt, cnt_at;
	logic [1:0]  mc = 2'h0;
	logic        bitstream_out_pin, bitstream_out_pin_oe;
	logic        conversion_ready_pin, conversion_ready_pin_oe;
	logic        oversample_select_low, internal_ref_enable;
	logic        ref_switch_on, analog_bias_enable, input_clock_enable;
	logic        core_clock_enable, core_reset, comm_enable;
	logic        analog_master_clock;
	int          error_cnt = 0, checked = 0, cyc = 0;

	rpbo_top rpbo_top_inst (
		.clock, .rst, .clk_en(1'h1), .reset_n_pin, .mode_pin, .mclk_pin,
		.watchdog_reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.mod_bit, .mod_bit_ready, .conv_ready, .bitstream_out_pin,
		.bitstream_out_pin_oe, .conversion_ready_pin,
		.conversion_ready_pin_oe, .oversample_select_low,
		.internal_ref_enable, .ref_switch_on, .analog_bias_enable,
		.input_clock_enable, .core_clock_enable, .core_reset,
		.comm_enable, .analog_master_clock
	);
	rpbo_host_model rpbo_host_model_inst (
		.clock, .rst, .analog_master_clock, .bitstream_out_pin,
		.bitstream_out_pin_oe, .bit_cnt, .last_bit
	);

	// Clock, master clock pin at a quarter rate, and the hang limit.
	always #20 clock = ~clock;
	always @(posedge clock) begin
		mc <= mc + 2'h1;
		if (mclk_run) mclk_pin <= mc[1];
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ========================================
	// Access tasks and comparison.
	task automatic chk(input logic [31:0] a, e);
		checked++;
		if (a !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, a, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock) addr <= a;
		wdata <= d;
		wr_stb <= 1'h1;
		@(posedge clock) wr_stb <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
		@(posedge clock) addr <= a;
		rd_stb <= 1'h1;
		@(posedge clock) rd_stb <= 1'h0;
		@(negedge clock);
		`CHK(rdata & m, e);
	endtask
	task automatic pulse_wd();
		@(posedge clock) watchdog_reset <= 1'h1;
		@(posedge clock) watchdog_reset <= 1'h0;
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence: reference, bitstream, chip reset, two-wire roles.
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'h0;
		repeat (4) @(posedge clock);
		pulse_wd();
		step(6);
		rd(`RPBO_STAT_ADDR, 32'h13, 32'h10);
		wr(`RPBO_CTRL_ADDR, 32'h1);
		rd(`RPBO_CTRL_ADDR, 32'h3, 32'h1);
		`CHK(internal_ref_enable | ref_switch_on, 1'h0);
		wr(`RPBO_CTRL_ADDR, 32'h0);
		rd(`RPBO_STAT_ADDR, 32'h10, 32'h10);
		`CHK(internal_ref_enable & ref_switch_on, 1'h1);
		rd(4'hC, 32'hFFFFFFFF, 32'h0);
		`CHK({bitstream_out_pin_oe, conversion_ready_pin_oe}, 2'h1);
		`CHK(mod_bit_ready, 1'h1);
		`CHK(conversion_ready_pin, 1'h1);
		@(posedge clock) conv_ready <= 1'h1;
		step(0);
		`CHK(conversion_ready_pin, 1'h0);
		@(posedge clock) conv_ready <= 1'h0;
		wr(`RPBO_CTRL_ADDR, 32'h2);
		@(posedge clock) mod_bit <= 1'h1;
		step(40);
		`CHK({bitstream_out_pin_oe, conversion_ready_pin_oe}, 2'h2);
		`CHK(last_bit, 1'h1);
		cnt_at = bit_cnt;
		@(posedge clock) mod_bit <= 1'h0;
		step(80);
		`CHK(last_bit, 1'h0);
		`CHK(bit_cnt - cnt_at > 8'h08, 1'h1);
		@(posedge clock) reset_n_pin <= 1'h0;
		step(10);
		`CHK({core_reset, comm_enable}, 2'h2);
		`CHK({core_clock_enable, input_clock_enable}, 2'h1);
		`CHK(analog_bias_enable, 1'h1);
		rd(`RPBO_CTRL_ADDR, 32'hFFFFFFFF, 32'h0);
		wr(`RPBO_CTRL_ADDR, 32'h1);
		@(posedge clock) mclk_run <= 1'h0;
		step(50);
		`CHK(input_clock_enable, 1'h0);
		@(posedge clock) reset_n_pin <= 1'h1;
		mclk_run <= 1'h1;
		step(12);
		`CHK({core_reset, comm_enable}, 2'h1);
		rd(`RPBO_CTRL_ADDR, 32'h3, 32'h0);
		rd(`RPBO_STAT_ADDR, 32'h8, 32'h8);
		step(80);
		rd(`RPBO_STAT_ADDR, 32'h8, 32'h0);
		wr(`RPBO_CTRL_ADDR, 32'h2);
		@(posedge clock) mode_pin <= 1'h1;
		step(4);
		pulse_wd();
		step(6);
		`CHK({comm_enable, conversion_ready_pin_oe}, 2'h0);
		`CHK(bitstream_out_pin_oe, 1'h0);
		`CHK(oversample_select_low, 1'h1);
		@(posedge clock) reset_n_pin <= 1'h0;
		step(8);
		`CHK({oversample_select_low, core_reset}, 2'h2);
		pulse_wd();
		step(6);
		`CHK(oversample_select_low, 1'h0);
		@(posedge clock) mode_pin <= 1'h0;
		reset_n_pin <= 1'h1;
		step(8);
		`CHK(comm_enable, 1'h0);
		pulse_wd();
		step(8);
		`CHK(comm_enable, 1'h1);
		print_verdict();
	end
endmodule // test_rpbo_top

bind rpbo_top rpbo_top_properties rpbo_top_properties_inst (
	.clock, .rst, .rd_stb, .rdata, .comm_enable, .bitstream_out_pin,
	.bitstream_out_pin_oe, .conversion_ready_pin_oe, .internal_ref_enable,
	.ref_switch_on, .analog_bias_enable, .input_clock_enable,
	.core_clock_enable, .core_reset, .analog_master_clock
);
